// *** rtl/seep_device.sv ***
// Device end: serial EEPROM command decoder, array and self-timed programming.
// Assumes link pins come from another domain; bench resolves the tri-state output.
`timescale 1ns/100ps
module seep_device #(
   parameter int PROG_CYCLES = seep_pkg::PROG_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   seep_link_if.device link
);
   typedef enum logic [2:0] {SEEPD_IDLE, SEEPD_OPC, SEEPD_ADDR, SEEPD_DATA, SEEPD_READ} seepd_state_t;
   typedef enum logic [1:0] {SEEPD_P_NONE, SEEPD_P_WORD, SEEPD_P_CLEAR, SEEPD_P_FILL} seepd_prog_t;

   logic [7:0]          mem_reg [seep_pkg::BYTES];
   logic [1:0]          cs_sync_reg;
   logic [2:0]          clk_sync_reg;
   logic [1:0]          di_sync_reg;
   logic [1:0]          org_sync_reg;
   logic                rise;
   logic                cs;
   logic                wide;
   seepd_state_t        state_reg;
   logic [4:0]          cnt_reg;
   logic [3:0]          opc_reg;
   logic [7:0]          addr_reg;
   logic [15:0]         data_reg;
   logic [16:0]         shout_reg;
   logic                unlocked_reg;
   seepd_prog_t         prog_reg;
   logic [31:0]         timer_reg;
   logic                so_reg;
   logic                oe_reg;

   // Synchronisers; first stages feed only second stages
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         cs_sync_reg  <= '0;
         clk_sync_reg <= '0;
         di_sync_reg  <= '0;
         org_sync_reg <= 2'h3;
      end
      else
      begin
         cs_sync_reg  <= {cs_sync_reg[0], link.chip_sel};
         clk_sync_reg <= {clk_sync_reg[1:0], link.link_clk};
         di_sync_reg  <= {di_sync_reg[0], link.serial_in};
         org_sync_reg <= {org_sync_reg[0], link.width_select_pin};
      end
   end

   assign rise = clk_sync_reg[1] && !clk_sync_reg[2];
   assign cs   = cs_sync_reg[1];
   assign wide = org_sync_reg[1];

   function automatic logic [7:0] addr_bits(input logic w);
      addr_bits = w ? 8'(seep_pkg::ADDR16_BITS) : 8'(seep_pkg::ADDR8_BITS);
   endfunction : addr_bits

   function automatic logic [7:0] data_bits(input logic w);
      data_bits = w ? 8'(seep_pkg::DATA16_BITS) : 8'(seep_pkg::DATA8_BITS);
   endfunction : data_bits

   // Command receive and read shift
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state_reg    <= SEEPD_IDLE;
         cnt_reg      <= '0;
         opc_reg      <= '0;
         addr_reg     <= '0;
         data_reg     <= '0;
         shout_reg    <= '0;
         so_reg       <= 1'b0;
         oe_reg       <= 1'b0;
         unlocked_reg <= 1'b0;
         prog_reg     <= SEEPD_P_NONE;
         timer_reg    <= '0;
      end
      else
      begin
         if (!cs)
         begin
            state_reg <= SEEPD_IDLE;
            oe_reg    <= 1'b0;
            cnt_reg   <= '0;
         end
         else if (rise)
         begin
            unique case (state_reg)
               SEEPD_IDLE:
               begin
                  if (di_sync_reg[1])
                  begin
                     state_reg <= SEEPD_OPC;
                     cnt_reg   <= '0;
                  end
               end
               SEEPD_OPC:
               begin
                  opc_reg <= {opc_reg[2:0], di_sync_reg[1]};
                  cnt_reg <= cnt_reg + 5'h01;
                  if (cnt_reg == 5'(seep_pkg::OPC_W - 1))
                  begin
                     state_reg <= SEEPD_ADDR;
                     cnt_reg   <= '0;
                  end
               end
               SEEPD_ADDR:
               begin
                  addr_reg <= {addr_reg[6:0], di_sync_reg[1]};
                  cnt_reg  <= cnt_reg + 5'h01;
                  if (cnt_reg == 5'(addr_bits(wide) - 8'h01))
                  begin
                     cnt_reg <= '0;
                     if (opc_reg == seep_pkg::OPC_READ)
                     begin
                        state_reg <= SEEPD_READ;
                        oe_reg    <= 1'b1;
                        so_reg    <= 1'b0;
                        if (wide)
                        begin
                           shout_reg <= {mem_reg[{addr_reg[5:0], di_sync_reg[1], 1'b1}],
                                         mem_reg[{addr_reg[5:0], di_sync_reg[1], 1'b0}], 1'b0};
                        end
                        else
                        begin
                           shout_reg <= {mem_reg[{addr_reg[6:0], di_sync_reg[1]}], 9'h000};
                        end
                     end
                     else if (opc_reg[2:0] == seep_pkg::OPC_PROG_LOW || opc_reg == seep_pkg::OPC_FILL_ALL)
                     begin
                        state_reg <= SEEPD_DATA;
                     end
                     else
                     begin
                        state_reg <= SEEPD_IDLE;
                        if (opc_reg == seep_pkg::OPC_UNLOCK)
                        begin
                           unlocked_reg <= 1'b1;
                        end
                        else if (opc_reg == seep_pkg::OPC_LOCK)
                        begin
                           unlocked_reg <= 1'b0;
                        end
                        else if (opc_reg == seep_pkg::OPC_CLEAR_ALL && unlocked_reg && prog_reg == SEEPD_P_NONE)
                        begin
                           prog_reg  <= SEEPD_P_CLEAR;
                           timer_reg <= '0;
                        end
                     end
                  end
               end
               SEEPD_DATA:
               begin
                  data_reg <= {data_reg[14:0], di_sync_reg[1]};
                  cnt_reg  <= cnt_reg + 5'h01;
                  if (cnt_reg == 5'(data_bits(wide) - 8'h01))
                  begin
                     state_reg <= SEEPD_IDLE;
                     if (unlocked_reg && prog_reg == SEEPD_P_NONE)
                     begin
                        prog_reg  <= (opc_reg == seep_pkg::OPC_FILL_ALL) ? SEEPD_P_FILL : SEEPD_P_WORD;
                        timer_reg <= '0;
                     end
                  end
               end
               SEEPD_READ:
               begin
                  so_reg    <= shout_reg[16];
                  shout_reg <= {shout_reg[15:0], 1'b0};
                  cnt_reg   <= cnt_reg + 5'h01;
                  if (cnt_reg == 5'(data_bits(wide)))
                  begin
                     state_reg <= SEEPD_IDLE;
                     oe_reg    <= 1'b0;
                  end
               end
               default:
               begin
                  state_reg <= SEEPD_IDLE;
               end
            endcase
         end

         // Self-timed cycle runs on the system clock only
         if (prog_reg != SEEPD_P_NONE)
         begin
            if (timer_reg >= 32'(PROG_CYCLES - 1))
            begin
               prog_reg <= SEEPD_P_NONE;
            end
            else
            begin
               timer_reg <= timer_reg + 32'h1;
            end
         end
      end
   end

   // Array update during the self-timed cycle
   always_ff @(posedge clk_in)
   begin
      if (prog_reg == SEEPD_P_WORD && timer_reg == '0)
      begin
         if (wide)
         begin
            mem_reg[{addr_reg[6:0], 1'b1}] <= data_reg[15:8];
            mem_reg[{addr_reg[6:0], 1'b0}] <= data_reg[7:0];
         end
         else
         begin
            mem_reg[addr_reg] <= data_reg[7:0];
         end
      end
      else if ((prog_reg == SEEPD_P_CLEAR || prog_reg == SEEPD_P_FILL) && timer_reg == '0)
      begin
         // Whole array in one cycle so busy time is set by the timer alone
         for (int j = 0; j < seep_pkg::BYTES; j++)
         begin
            if (prog_reg == SEEPD_P_CLEAR)
            begin
               mem_reg[j] <= seep_pkg::ERASED_BYTE;
            end
            else
            begin
               mem_reg[j] <= (wide && j[0]) ? data_reg[15:8] : data_reg[7:0];
            end
         end
      end
   end

   assign link.serial_out    = so_reg;
   assign link.serial_out_oe = oe_reg;
   assign link.ready         = (prog_reg == SEEPD_P_NONE);
endmodule : seep_device

// *** rtl/seep_pkg.sv ***
// Constants shared by the serial EEPROM device and host ends.
// Assumes a single 10 MHz system clock on both ends.
package seep_pkg;
   localparam int          CLK_HZ          = 10000000;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 16;
   localparam int          OPC_W           = 4;
   localparam int          WORDS16         = 128;
   localparam int          WORDS8          = 256;
   localparam int          BYTES           = 256;
   localparam int          ADDR16_BITS     = 7;
   localparam int          ADDR8_BITS      = 8;
   localparam int          DATA16_BITS     = 16;
   localparam int          DATA8_BITS      = 8;
   localparam int          PROG_TIME_MS    = 10;
   localparam int          PROG_CYCLES     = PROG_TIME_MS * (CLK_HZ / 1000);
   localparam int          LINK_HALF_CYC   = 4;
   localparam logic [3:0]  OPC_READ        = 4'h8;
   localparam logic [2:0]  OPC_PROG_LOW    = 3'h4;
   localparam logic [3:0]  OPC_UNLOCK      = 4'h3;
   localparam logic [3:0]  OPC_LOCK        = 4'h0;
   localparam logic [3:0]  OPC_CLEAR_ALL   = 4'h2;
   localparam logic [3:0]  OPC_FILL_ALL    = 4'h1;
   localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
endpackage : seep_pkg

// *** rtl/seep_link_if.sv ***
// Serial link between the host end and the device end.
// Assumes both ends run on the same bench; serial output is tri-state.
`timescale 1ns/100ps
interface seep_link_if;
   logic chip_sel;
   logic link_clk;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe;
   logic ready;
   logic width_select_pin;
   modport device (input chip_sel, link_clk, serial_in, width_select_pin, output serial_out, serial_out_oe, ready);
   modport host (output chip_sel, link_clk, serial_in, input serial_out, serial_out_oe, ready);
endinterface : seep_link_if

// *** rtl/seep_fifo.sv ***
// Valid/ready FIFO for read data on the host end.
// Assumes one clock domain.
`timescale 1ns/100ps
module seep_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             arst_n_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_reg;
   logic [AW-1:0]    rd_reg;
   logic [AW:0]      cnt_reg;
   logic             push;
   logic             pop;

   assign in_ready_out  = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid_out = cnt_reg != '0;
   assign out_data_out  = mem_reg[rd_reg];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_ff @(posedge clk_in)
   begin
      if (push)
      begin
         mem_reg[wr_reg] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         end
         if (pop)
         begin
            rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : seep_fifo

// *** rtl/seep_host.sv ***
// Host end: issues instructions over the serial link and queues read words.
// Assumes the device end synchronises the link pins it receives.
`timescale 1ns/100ps
module seep_host #(
   parameter int HALF_CYC = seep_pkg::LINK_HALF_CYC
) (
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        cmd_valid_in,
   output logic             cmd_ready_out,
   input  wire logic [3:0]  cmd_opc_in,
   input  wire logic [7:0]  cmd_addr_in,
   input  wire logic [15:0] cmd_data_in,
   input  wire logic        wide_in,
   output logic             rd_valid_out,
   input  wire logic        rd_ready_in,
   output logic [15:0]      rd_data_out,
   output logic             dev_ready_out,
   seep_link_if.host link
);
   typedef enum logic [1:0] {SEEPH_IDLE, SEEPH_SHIFT, SEEPH_PUSH} seeph_state_t;
   seeph_state_t state_reg;
   logic [28:0]  sh_reg;
   logic [5:0]   bits_reg;
   logic [5:0]   rbits_reg;
   logic [15:0]  rd_reg;
   logic         is_read_reg;
   logic [7:0]   div_reg;
   logic         sck_reg;
   logic         cs_reg;
   logic [1:0]   do_sync_reg;
   logic [1:0]   rdy_sync_reg;
   logic         fifo_ready;
   logic         tick;
   logic [4:0]   alen;
   logic [4:0]   dlen;
   logic         has_data;

   assign tick     = div_reg == 8'(HALF_CYC - 1);
   assign alen     = wide_in ? 5'(seep_pkg::ADDR16_BITS) : 5'(seep_pkg::ADDR8_BITS);
   assign dlen     = wide_in ? 5'(seep_pkg::DATA16_BITS) : 5'(seep_pkg::DATA8_BITS);
   assign has_data = (cmd_opc_in[2:0] == seep_pkg::OPC_PROG_LOW) || (cmd_opc_in == seep_pkg::OPC_FILL_ALL);
   assign cmd_ready_out = (state_reg == SEEPH_IDLE);

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         do_sync_reg  <= '0;
         rdy_sync_reg <= '0;
      end
      else
      begin
         do_sync_reg  <= {do_sync_reg[0], link.serial_out};
         rdy_sync_reg <= {rdy_sync_reg[0], link.ready};
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         state_reg   <= SEEPH_IDLE;
         sh_reg      <= '0;
         bits_reg    <= '0;
         rbits_reg   <= '0;
         rd_reg      <= '0;
         is_read_reg <= 1'b0;
         div_reg     <= '0;
         sck_reg     <= 1'b0;
         cs_reg      <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            SEEPH_IDLE:
            begin
               if (cmd_valid_in)
               begin
                  // Start bit, opcode, address, data left-aligned
                  if (!wide_in)
                  begin
                     sh_reg <= {1'b1, cmd_opc_in, cmd_addr_in, cmd_data_in[7:0], 8'h00};
                  end
                  else
                  begin
                     sh_reg <= {1'b1, cmd_opc_in, cmd_addr_in[6:0], cmd_data_in, 1'b0};
                  end
                  bits_reg    <= 6'(1 + seep_pkg::OPC_W) + 6'(alen) + (has_data ? 6'(dlen) : 6'h00);
                  rbits_reg   <= (cmd_opc_in == seep_pkg::OPC_READ) ? 6'(dlen) + 6'h01 : 6'h00;
                  is_read_reg <= cmd_opc_in == seep_pkg::OPC_READ;
                  rd_reg      <= '0;
                  cs_reg      <= 1'b1;
                  div_reg     <= '0;
                  state_reg   <= SEEPH_SHIFT;
               end
            end
            SEEPH_SHIFT:
            begin
               div_reg <= tick ? 8'h00 : div_reg + 8'h01;
               if (tick)
               begin
                  sck_reg <= !sck_reg;
                  if (!sck_reg)
                  begin
                     if (bits_reg != '0)
                     begin
                        bits_reg <= bits_reg - 6'h01;
                     end
                     else if (rbits_reg != '0)
                     begin
                        // Sampled a full period after launch to cover both synchroniser lags
                        rbits_reg <= rbits_reg - 6'h01;
                        rd_reg    <= {rd_reg[14:0], do_sync_reg[1]};
                     end
                  end
                  else
                  begin
                     if (bits_reg != '0)
                     begin
                        sh_reg <= {sh_reg[27:0], 1'b0};
                     end
                     else if (rbits_reg == '0)
                     begin
                        cs_reg    <= 1'b0;
                        state_reg <= is_read_reg ? SEEPH_PUSH : SEEPH_IDLE;
                     end
                  end
               end
            end
            SEEPH_PUSH:
            begin
               if (fifo_ready)
               begin
                  state_reg <= SEEPH_IDLE;
               end
            end
            default:
            begin
               state_reg <= SEEPH_IDLE;
            end
         endcase
      end
   end

   seep_fifo #(.WIDTH(16), .DEPTH(8)) u_fifo (
      .clk_in        (clk_in),
      .arst_n_in     (arst_n_in),
      .in_valid_in   (state_reg == SEEPH_PUSH),
      .in_ready_out  (fifo_ready),
      .in_data_in    (rd_reg),
      .out_valid_out (rd_valid_out),
      .out_ready_in  (rd_ready_in),
      .out_data_out  (rd_data_out)
   );

   assign link.chip_sel  = cs_reg;
   assign link.link_clk  = sck_reg;
   assign link.serial_in = sh_reg[28];
   assign dev_ready_out  = rdy_sync_reg[1];
endmodule : seep_host

// *** dv/seep_link_sva.sv ***
// Checker of the serial link between the host and device ends.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/100ps
module seep_link_sva #(
   parameter int PROG_CYCLES = seep_pkg::PROG_CYCLES
) (
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   input  wire logic chip_sel,
   input  wire logic link_clk,
   input  wire logic serial_in,
   input  wire logic serial_out,
   input  wire logic serial_out_oe,
   input  wire logic ready,
   input  wire logic width_select_pin
);
   logic [7:0]  rise_cnt_reg;
   logic [8:0]  oe_cnt_reg;
   logic [8:0]  cs_cnt_reg;
   logic [31:0] busy_cnt_reg;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in) rise_cnt_reg <= 8'h00;
      else rise_cnt_reg <= $rose(link_clk) ? 8'h00 : (rise_cnt_reg == 8'hFF ? 8'hFF : rise_cnt_reg + 8'h01);
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in) oe_cnt_reg <= 9'h000;
      else oe_cnt_reg <= serial_out_oe ? oe_cnt_reg + 9'h001 : 9'h000;
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in) cs_cnt_reg <= 9'h000;
      else cs_cnt_reg <= chip_sel ? (cs_cnt_reg == 9'h1FF ? 9'h1FF : cs_cnt_reg + 9'h001) : 9'h000;
   always_ff @(posedge clk_in or negedge arst_n_in)
      if (!arst_n_in) busy_cnt_reg <= 32'h0;
      else busy_cnt_reg <= ready ? 32'h0 : busy_cnt_reg + 32'h1;
   property p_oe_in_frame; serial_out_oe |-> chip_sel; endproperty
   a_oe_in_frame: assert property (p_oe_in_frame) else $error("output driven outside frame");
   property p_oe_off; $fell(chip_sel) |-> ##[0:5] !serial_out_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("output still driven after deselect");
   property p_dummy; $rose(serial_out_oe) |-> !serial_out; endproperty
   a_dummy: assert property (p_dummy) else $error("first read bit not zero");
   property p_oe_len; serial_out_oe |-> oe_cnt_reg <= 9'd160; endproperty
   a_oe_len: assert property (p_oe_len) else $error("read output held too long");
   property p_edge; $changed(serial_out) && serial_out_oe && $past(serial_out_oe) |-> rise_cnt_reg <= 8'd6; endproperty
   a_edge: assert property (p_edge) else $error("read bit changed away from rising edge");
   property p_hdr; $rose(serial_out_oe) |-> cs_cnt_reg >= (width_select_pin ? 9'd80 : 9'd88); endproperty
   a_hdr: assert property (p_hdr) else $error("read output before address complete");
   property p_busy_end; $fell(ready) |-> ##[0:20] !chip_sel; endproperty
   a_busy_end: assert property (p_busy_end) else $error("busy not at end of frame");
   property p_busy_min; $fell(ready) |-> !ready [*8]; endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy pulse too short");
   property p_busy_max; !ready |-> busy_cnt_reg <= PROG_CYCLES + 20; endproperty
   a_busy_max: assert property (p_busy_max) else $error("busy never ended");
   property p_rd_idle; serial_out_oe |-> ready; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read during busy");
   c_read: cover property ($rose(serial_out_oe));
   c_byte: cover property ($rose(serial_out_oe) && !width_select_pin);
   c_prog: cover property ($fell(ready));
endmodule : seep_link_sva

// *** dv/test_serial_eeprom_2k_protocol.sv ***
// Testbench joining host and device ends over the link interface.
// Assumes both ends and the link checker compile before it.
`timescale 1ns/100ps
module test_serial_eeprom_2k_protocol;
   localparam int PROG = 50;
   logic        clk_in    = 1'b0;
   logic        arst_n_in = 1'b0;
   logic        cmd_valid = 1'b0;
   logic [3:0]  cmd_opc   = 4'h0;
   logic [7:0]  cmd_addr  = 8'h00;
   logic [15:0] cmd_data  = 16'h0000;
   logic        wide      = 1'b1;
   logic        rd_ready  = 1'b0;
   logic        cmd_ready;
   logic        rd_valid;
   logic        dev_ready;
   logic [15:0] rd_data;
   logic        first_bit = 1'b0;
   int          n_fail = 0;
   int          checks_done = 0;
   int          i;
   seep_link_if seep_link_if_i ();
   seep_device #(.PROG_CYCLES(PROG)) seep_device_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .link(seep_link_if_i));
   seep_host seep_host_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready),
      .cmd_opc_in(cmd_opc), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data), .wide_in(wide), .rd_valid_out(rd_valid),
      .rd_ready_in(rd_ready), .rd_data_out(rd_data), .dev_ready_out(dev_ready), .link(seep_link_if_i));
   seep_link_sva #(.PROG_CYCLES(PROG)) seep_link_sva_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .chip_sel(seep_link_if_i.chip_sel), .link_clk(seep_link_if_i.link_clk), .serial_in(seep_link_if_i.serial_in),
      .serial_out(seep_link_if_i.serial_out), .serial_out_oe(seep_link_if_i.serial_out_oe),
      .ready(seep_link_if_i.ready), .width_select_pin(seep_link_if_i.width_select_pin));
   always #50 clk_in = ~clk_in;
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic send(input logic [3:0] opc, input logic [7:0] addr, input logic [15:0] data);
      int k;
      @(posedge clk_in);
      #10;
      cmd_valid = 1'b1;
      cmd_opc = opc;
      cmd_addr = addr;
      cmd_data = data;
      for (k = 0; k < 2000 && cmd_ready !== 1'b1; k++) @(posedge clk_in) #10;
      if (cmd_ready !== 1'b1) n_fail++;
      @(posedge clk_in);
      #10;
      cmd_valid = 1'b0;
   endtask : send
   task automatic prog_wait(input logic exp_busy);
      logic seen_busy;
      seen_busy = 1'b0;
      repeat (400)
      begin
         @(posedge clk_in);
         #10;
         if (dev_ready === 1'b0) seen_busy = 1'b1;
      end
      check({15'h0, seen_busy}, {15'h0, exp_busy});
      check({15'h0, dev_ready}, 16'h0001);
   endtask : prog_wait
   task automatic pop(input logic [15:0] exp);
      int k;
      for (k = 0; k < 1000; k++)
      begin
         @(posedge clk_in);
         #10;
         if (rd_valid === 1'b1) break;
      end
      check({15'h0, rd_valid}, 16'h0001);
      check(rd_data, exp);
      rd_ready = 1'b1;
      @(posedge clk_in);
      #10;
      rd_ready = 1'b0;
   endtask : pop
   task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
      send(seep_pkg::OPC_READ, addr, 16'h0000);
      pop(exp);
   endtask : rd
   task automatic final_report;
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report
   // Start bit leads every frame
   always @(posedge seep_link_if_i.chip_sel) first_bit = 1'b1;
   always @(posedge seep_link_if_i.link_clk)
      if (first_bit)
      begin
         check({15'h0, seep_link_if_i.serial_in}, 16'h0001);
         first_bit = 1'b0;
      end
   initial
   begin
      seep_link_if_i.width_select_pin = 1'b1;
      repeat (5) @(posedge clk_in);
      #10 arst_n_in = 1'b1;
      send(seep_pkg::OPC_CLEAR_ALL, 8'h00, 16'h0000);
      prog_wait(1'b0);
      send(seep_pkg::OPC_UNLOCK, 8'h00, 16'h0000);
      send(seep_pkg::OPC_CLEAR_ALL, 8'h00, 16'h0000);
      prog_wait(1'b1);
      rd(8'h05, 16'hFFFF);
      send({1'b1, seep_pkg::OPC_PROG_LOW}, 8'h05, 16'hA55A);
      prog_wait(1'b1);
      rd(8'h05, 16'hA55A);
      $display("test unlock and program done");
      send(seep_pkg::OPC_LOCK, 8'h00, 16'h0000);
      send({1'b0, seep_pkg::OPC_PROG_LOW}, 8'h05, 16'h0000);
      prog_wait(1'b0);
      rd(8'h05, 16'hA55A);
      $display("test lock done");
      send(seep_pkg::OPC_UNLOCK, 8'h00, 16'h0000);
      send(seep_pkg::OPC_CLEAR_ALL, 8'h00, 16'h0000);
      prog_wait(1'b1);
      send(seep_pkg::OPC_FILL_ALL, 8'h00, 16'h1234);
      prog_wait(1'b1);
      rd(8'h00, 16'h1234);
      rd(8'h7F, 16'h1234);
      $display("test fill done");
      seep_link_if_i.width_select_pin = 1'b0;
      wide = 1'b0;
      rd(8'h00, 16'h0034);
      rd(8'h01, 16'h0012);
      send({1'b0, seep_pkg::OPC_PROG_LOW}, 8'hFF, 16'h005A);
      prog_wait(1'b1);
      rd(8'hFF, 16'h005A);
      seep_link_if_i.width_select_pin = 1'b1;
      wide = 1'b1;
      rd(8'h7F, 16'h5A34);
      $display("test byte mode done");
      for (i = 0; i < 8; i++) send(seep_pkg::OPC_READ, i[0] ? 8'h7F : 8'h00, 16'h0000);
      for (i = 0; i < 8; i++) pop(i[0] ? 16'h5A34 : 16'h1234);
      $display("test read queue done");
      final_report;
   end
   initial
   begin
      #4000000;
      n_fail++;
      final_report;
   end
endmodule : test_serial_eeprom_2k_protocol
